// ==== hdl/gp_pkg.sv ====
// Constants for the two-port general I/O block with its high pin-change mask
package gp_pkg;

	localparam int GP_PORT_W = 8;
	localparam int GP_PINS = 16;

	// Register byte addresses
	localparam logic [7:0] GP_ADDR_IN_B = 8'h16;
	localparam logic [7:0] GP_ADDR_DIR_B = 8'h17;
	localparam logic [7:0] GP_ADDR_OUT_B = 8'h18;
	localparam logic [7:0] GP_ADDR_IN_A = 8'h19;
	localparam logic [7:0] GP_ADDR_DIR_A = 8'h1A;
	localparam logic [7:0] GP_ADDR_OUT_A = 8'h1B;
	localparam logic [7:0] GP_ADDR_PC_MASK_HIGH = 8'h22;
	localparam logic [7:0] GP_ADDR_PUE_A = 8'h30;
	localparam logic [7:0] GP_ADDR_PUE_B = 8'h31;
	localparam logic [7:0] GP_ADDR_MICRO_CTRL = 8'h35;
	localparam logic [7:0] GP_ADDR_FLAG = 8'h3A;
	localparam logic [7:0] GP_ADDR_GEN_INT_MASK = 8'h3B;

	// Field positions
	localparam int GP_BIT_PULLUP_DISABLE = 6;
	localparam int GP_BIT_GROUP_EN_B = 5;
	localparam int GP_BIT_GROUP_EN_A = 4;
	localparam int GP_BIT_PC_FLAG = 5;

	// Mask bits 3:0 belong to group a, 7:4 to group b
	localparam int GP_GROUP_SPLIT = 4;

	// Reset values
	localparam logic [7:0] GP_RST_PC_MASK_HIGH = 8'hFF;
	localparam logic [7:0] GP_RST_BYTE = 8'h00;
	localparam logic [15:0] GP_RST_WORD = 16'h0000;
	localparam logic [7:0] GP_READ_ZERO = 8'h00;

endpackage

// ==== hdl/gp_io_port.sv ====
// Two 8-bit general I/O ports with pull-ups, toggle, sleep clamp and high pin-change gating
//
// Notes on behaviour
// - Pins 11:8 detect when mask and group a set
// - Pins 15:12 detect when mask and group b set
// - Cleared mask bit disables that pin's detection
// - Each port: output, direction, read-only input register
// - Writing one to input bit toggles output bit
// - Global pull-up disable kills every pull-up
// - Direction one means output, zero means input
// - Input with output bit one gets pull-up
// - Output pin drives its output bit value
// - Reset makes every pin high impedance, clockless
// - Separate pull-up enable bit switches pull-up
// - Pin level readable, half to 1.5 cycles
// - Falling-edge capture, then rising-edge input register
// - Written value readable one cycle later; software waits
// - Deep sleep clamps digital inputs to ground
// - External interrupt enabled pins escape the clamp
// - Clamp release yields edge on disabled interrupt pin
// - Register writes leave other pins' settings untouched
// - Each pin's logic independent of other pins
// - Enabled change sets shared flag; ack or write clears
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module gp_io_port
	import gp_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WE_I,
	input wire logic RE_I,
	output logic [7:0] RDATA_O,
	input wire logic [15:0] PIN_I,
	output logic [15:0] PIN_O,
	output logic [15:0] PIN_OE_N_O,
	output logic [15:0] PULLUP_O,
	input wire logic SLEEP_I,
	input wire logic [15:0] EXT_INT_EN_I,
	input wire logic PC_ACK_I,
	output logic PIN_CHANGE_REQ_O,
	output logic PIN_CHANGE_FLAG_O
);

	logic [15:0] out_q;
	logic [15:0] dir_q;
	logic [15:0] pue_q;
	logic [7:0] pc_mask_q;
	logic pud_q;
	logic group_en_a_q;
	logic group_en_b_q;
	logic flag_q;
	logic flag_d;
	logic [15:0] sync_lat_q;
	logic [15:0] in_q;
	logic [15:0] prev_q;
	logic [15:0] in_clamped;
	logic [7:0] pc_enable;
	logic [7:0] pc_change;
	logic pc_req;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [15:0] toggle;
	logic wr_flag_clear;

	////////////////////////////////////////////////////////////////////////////////
	// Register writes

	// A toggle write never touches direction, so it works on inputs too
	always_comb begin
		toggle = GP_RST_WORD;
		if (WE_I && ADDR_I == GP_ADDR_IN_A) begin
			toggle[GP_PORT_W-1:0] = WDATA_I;
		end
		if (WE_I && ADDR_I == GP_ADDR_IN_B) begin
			toggle[GP_PINS-1:GP_PORT_W] = WDATA_I;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			out_q <= GP_RST_WORD;
		end else if (WE_I && ADDR_I == GP_ADDR_OUT_A) begin
			out_q[GP_PORT_W-1:0] <= WDATA_I;
		end else if (WE_I && ADDR_I == GP_ADDR_OUT_B) begin
			out_q[GP_PINS-1:GP_PORT_W] <= WDATA_I;
		end else begin
			out_q <= out_q ^ toggle;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			dir_q <= GP_RST_WORD;
		end else if (WE_I && ADDR_I == GP_ADDR_DIR_A) begin
			dir_q[GP_PORT_W-1:0] <= WDATA_I;
		end else if (WE_I && ADDR_I == GP_ADDR_DIR_B) begin
			dir_q[GP_PINS-1:GP_PORT_W] <= WDATA_I;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pue_q <= GP_RST_WORD;
		end else if (WE_I && ADDR_I == GP_ADDR_PUE_A) begin
			pue_q[GP_PORT_W-1:0] <= WDATA_I;
		end else if (WE_I && ADDR_I == GP_ADDR_PUE_B) begin
			pue_q[GP_PINS-1:GP_PORT_W] <= WDATA_I;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pc_mask_q <= GP_RST_PC_MASK_HIGH;
		end else if (WE_I && ADDR_I == GP_ADDR_PC_MASK_HIGH) begin
			pc_mask_q <= WDATA_I;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pud_q <= 1'b0;
		end else if (WE_I && ADDR_I == GP_ADDR_MICRO_CTRL) begin
			pud_q <= WDATA_I[GP_BIT_PULLUP_DISABLE];
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			group_en_a_q <= 1'b0;
			group_en_b_q <= 1'b0;
		end else if (WE_I && ADDR_I == GP_ADDR_GEN_INT_MASK) begin
			group_en_a_q <= WDATA_I[GP_BIT_GROUP_EN_A];
			group_en_b_q <= WDATA_I[GP_BIT_GROUP_EN_B];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers and pull-ups

	// Reset gates the enables directly so pins float even without a clock
	assign PIN_OE_N_O = ~dir_q | {GP_PINS{RST_I}};
	assign PIN_O = out_q;
	// Pull-up enable bit and the input-high setting both count; disable overrides both
	assign PULLUP_O = {GP_PINS{~pud_q & ~RST_I}} & ((~dir_q & out_q) | pue_q);

	////////////////////////////////////////////////////////////////////////////////
	// Input path

	// Sleep clamp holds inputs low except pins with EXT_INT_EN_I set; waking then looks like a rising edge on a high pin
	assign in_clamped = PIN_I & ~({GP_PINS{SLEEP_I}} & ~EXT_INT_EN_I);

	// Falling-edge stage stands in for the clock-high transparent latch
	always_ff @(negedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sync_lat_q <= GP_RST_WORD;
		end else begin
			sync_lat_q <= in_clamped;
		end
	end

	// Output writes land here one period later, hence the software wait
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			in_q <= GP_RST_WORD;
		end else begin
			in_q <= sync_lat_q;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			prev_q <= GP_RST_WORD;
		end else begin
			prev_q <= in_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin-change detection for pins 15:8

	assign pc_enable[GP_GROUP_SPLIT-1:0] = pc_mask_q[GP_GROUP_SPLIT-1:0] & {GP_GROUP_SPLIT{group_en_a_q}};
	assign pc_enable[7:GP_GROUP_SPLIT] = pc_mask_q[7:GP_GROUP_SPLIT] & {GP_GROUP_SPLIT{group_en_b_q}};
	assign pc_change = (in_q[GP_PINS-1:GP_PORT_W] ^ prev_q[GP_PINS-1:GP_PORT_W]) & pc_enable;
	assign pc_req = |pc_change;
	assign PIN_CHANGE_REQ_O = pc_req;

	assign wr_flag_clear = WE_I && ADDR_I == GP_ADDR_FLAG && WDATA_I[GP_BIT_PC_FLAG];

	// A change in the clearing cycle keeps the flag set
	always_comb begin
		flag_d = flag_q;
		if (wr_flag_clear || PC_ACK_I) begin
			flag_d = 1'b0;
		end
		if (pc_req) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign PIN_CHANGE_FLAG_O = flag_q;

	////////////////////////////////////////////////////////////////////////////////
	// Register reads, one cycle after the strobe

	always_comb begin
		rdata_d = GP_READ_ZERO;
		case (ADDR_I)
			GP_ADDR_IN_A: rdata_d = in_q[GP_PORT_W-1:0];
			GP_ADDR_IN_B: rdata_d = in_q[GP_PINS-1:GP_PORT_W];
			GP_ADDR_OUT_A: rdata_d = out_q[GP_PORT_W-1:0];
			GP_ADDR_OUT_B: rdata_d = out_q[GP_PINS-1:GP_PORT_W];
			GP_ADDR_DIR_A: rdata_d = dir_q[GP_PORT_W-1:0];
			GP_ADDR_DIR_B: rdata_d = dir_q[GP_PINS-1:GP_PORT_W];
			GP_ADDR_PUE_A: rdata_d = pue_q[GP_PORT_W-1:0];
			GP_ADDR_PUE_B: rdata_d = pue_q[GP_PINS-1:GP_PORT_W];
			GP_ADDR_PC_MASK_HIGH: rdata_d = pc_mask_q;
			GP_ADDR_MICRO_CTRL: rdata_d[GP_BIT_PULLUP_DISABLE] = pud_q;
			GP_ADDR_FLAG: rdata_d[GP_BIT_PC_FLAG] = flag_q;
			GP_ADDR_GEN_INT_MASK: begin
				rdata_d[GP_BIT_GROUP_EN_A] = group_en_a_q;
				rdata_d[GP_BIT_GROUP_EN_B] = group_en_b_q;
			end
			default: rdata_d = GP_READ_ZERO;
		endcase
		if (!RE_I) begin
			rdata_d = GP_READ_ZERO;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_q <= GP_READ_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign RDATA_O = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	group_a_detect_a: assert property (
		(group_en_a_q && |((in_q[11:8] ^ prev_q[11:8]) & pc_mask_q[3:0])) |-> PIN_CHANGE_REQ_O ##1 PIN_CHANGE_FLAG_O)
		else $error("group a change not reported");

	group_b_detect_a: assert property (
		(group_en_b_q && |((in_q[15:12] ^ prev_q[15:12]) & pc_mask_q[7:4])) |-> PIN_CHANGE_REQ_O)
		else $error("group b change not reported");

	masked_quiet_a: assert property (
		PIN_CHANGE_REQ_O |-> |((in_q[15:8] ^ prev_q[15:8]) & pc_mask_q))
		else $error("request without unmasked change");

	toggle_write_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_IN_B) |=> (PIN_O[15:8] == ($past(PIN_O[15:8]) ^ $past(WDATA_I))))
		else $error("input write did not toggle output");

	pullup_disable_a: assert property (
		pud_q |-> PULLUP_O == GP_RST_WORD)
		else $error("pull-up on while globally disabled");

	drive_dir_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_DIR_A) |=> (PIN_OE_N_O[7:0] == ~$past(WDATA_I)))
		else $error("direction write not reflected on enable");

	pullup_input_a: assert property (
		!pud_q |-> ((PULLUP_O & ~dir_q & out_q) == (~dir_q & out_q)))
		else $error("input high without pull-up");

	reset_float_a: assert property (disable iff (1'b0) RST_I |-> &PIN_OE_N_O)
		else $error("pin driven during reset");

	pue_on_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_PUE_A && !pud_q) ##1 !pud_q |-> (PULLUP_O[7:0] & $past(WDATA_I)) == $past(WDATA_I))
		else $error("pull-up enable write ignored");

	sync_delay_a: assert property (
		##1 in_q == $past(in_clamped))
		else $error("input path delay wrong");

	flag_hold_a: assert property (
		(flag_q && !PC_ACK_I && !wr_flag_clear) |=> flag_q)
		else $error("flag lost without clear");

	// Pin drive follows register writes on the next cycle
	out_a_write_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_OUT_A) |=> (PIN_O[7:0] == $past(WDATA_I)))
		else $error("port a drive value wrong");

	out_b_write_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_OUT_B) |=> (PIN_O[15:8] == $past(WDATA_I)))
		else $error("port b drive value wrong");

	dir_b_write_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_DIR_B) |=> (PIN_OE_N_O[15:8] == ~$past(WDATA_I)))
		else $error("port b direction not on enable");

	toggle_a_write_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_IN_A) |=> (PIN_O[7:0] == ($past(PIN_O[7:0]) ^ $past(WDATA_I))))
		else $error("port a toggle wrong");

	read_idle_a: assert property (
		!$past(RE_I) |-> (RDATA_O == GP_READ_ZERO))
		else $error("read data without strobe");

	read_input_a: assert property (
		($past(RE_I) && $past(ADDR_I) == GP_ADDR_IN_B) |-> (RDATA_O == $past(in_q[15:8])))
		else $error("input register read wrong");

	read_dir_a: assert property (
		($past(RE_I) && $past(ADDR_I) == GP_ADDR_DIR_A) |-> (RDATA_O == $past(dir_q[7:0])))
		else $error("direction read wrong");

	input_ro_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_IN_A) |=> (dir_q == $past(dir_q) && pue_q == $past(pue_q)))
		else $error("input write changed settings");

	// Byte writes must leave the other port alone
	dir_other_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_DIR_A) |=> (dir_q[15:8] == $past(dir_q[15:8])))
		else $error("direction write hit other port");

	out_other_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_OUT_B) |=> (out_q[7:0] == $past(out_q[7:0])))
		else $error("output write hit other port");

	pue_other_a: assert property (
		(WE_I && ADDR_I == GP_ADDR_PUE_A) |=> (pue_q[15:8] == $past(pue_q[15:8])))
		else $error("pull-up write hit other port");

	sleep_clamp_a: assert property (
		SLEEP_I |-> ((in_clamped & ~EXT_INT_EN_I) == GP_RST_WORD))
		else $error("input not clamped in sleep");

	clamp_exempt_a: assert property (
		SLEEP_I |-> ((in_clamped & EXT_INT_EN_I) == (PIN_I & EXT_INT_EN_I)))
		else $error("interrupt pin clamped in sleep");

	awake_pass_a: assert property (
		!SLEEP_I |-> (in_clamped == PIN_I))
		else $error("input clamped while awake");

	output_no_pullup_a: assert property (
		((PULLUP_O & dir_q & ~pue_q) == GP_RST_WORD))
		else $error("pull-up on an output pin");

	pue_pullup_a: assert property (
		!pud_q |-> ((PULLUP_O & pue_q) == pue_q))
		else $error("pull-up enable bit ignored");

	change_quiet_a: assert property (
		(in_q == prev_q) |-> !PIN_CHANGE_REQ_O)
		else $error("request without any change");

	flag_set_a: assert property (
		PIN_CHANGE_REQ_O |=> PIN_CHANGE_FLAG_O)
		else $error("flag not set by request");

	flag_clear_a: assert property (
		(PC_ACK_I && !PIN_CHANGE_REQ_O) |=> !PIN_CHANGE_FLAG_O)
		else $error("flag not cleared by service");

endmodule

// ==== bench/gp_pin_model.sv ====
// Pin-side model: external drivers, pull-ups and floating pins
`timescale 1ns/10ps
module gp_pin_model (
	input wire logic clk_i,
	input wire logic [15:0] drive_i,
	input wire logic [15:0] oe_n_i,
	input wire logic [15:0] pullup_i,
	input wire logic [15:0] ext_val_i,
	input wire logic [15:0] ext_en_i,
	output logic [15:0] level_o
);
	// A floating pad must not look like a steady level, so it flips each cycle
	logic flip_q = 1'b0;
	always @(posedge clk_i) begin
		flip_q <= ~flip_q;
	end
	always_comb begin
		for (int n = 0; n < 16; n++) begin
			if (!oe_n_i[n])
				level_o[n] = drive_i[n];
			else if (ext_en_i[n])
				level_o[n] = ext_val_i[n];
			else if (pullup_i[n])
				level_o[n] = 1'b1;
			else
				level_o[n] = flip_q;
		end
	end
endmodule

// ==== bench/gp_io_port_tb.sv ====
// Self-checking testbench for the two-port general I/O block
`timescale 1ns/10ps
module gp_io_port_tb
	import gp_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic we = 1'b0;
	logic re = 1'b0;
	logic sleep = 1'b0;
	logic ack = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [15:0] ext_val = 16'h0000;
	logic [15:0] ext_en = 16'hFFFF;
	logic [15:0] eie = 16'h0000;
	logic [7:0] rdata;
	logic [15:0] pin_i, pin_o, oe_n, pu;
	logic req, flag;
	int fail_count = 0;
	int comparisons = 0;

	always #12.5 clk = ~clk;

	gp_io_port i_dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we), .RE_I(re),
		.RDATA_O(rdata), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N_O(oe_n), .PULLUP_O(pu), .SLEEP_I(sleep),
		.EXT_INT_EN_I(eie), .PC_ACK_I(ack), .PIN_CHANGE_REQ_O(req), .PIN_CHANGE_FLAG_O(flag));
	gp_pin_model i_pins (.clk_i(clk), .drive_i(pin_o), .oe_n_i(oe_n), .pullup_i(pu), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .level_o(pin_i));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		chk({8'h00, rdata}, {8'h00, exp});
	endtask
	// Request is one cycle wide, so count it over a short window
	task automatic pulse(input int n, input int exp_cnt);
		int cnt;
		cnt = 0;
		@(posedge clk);
		ext_val[n] <= ~ext_val[n];
		repeat (5) begin
			@(posedge clk);
			#1;
			if (req === 1'b1)
				cnt++;
		end
		chk(16'(cnt), 16'(exp_cnt));
	endtask
	task automatic stop_test;
		$display("Counts: %0d compared, %0d bad", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		#1;
		chk(oe_n, 16'hFFFF);
		chk(pu, 16'h0000);
		@(posedge clk);
		rst <= 1'b0;
		rd(GP_ADDR_PC_MASK_HIGH, GP_RST_PC_MASK_HIGH);
		rd(GP_ADDR_DIR_A, GP_RST_BYTE);
		rd(8'h00, GP_READ_ZERO);
		$display("Test reset done");
		wr(GP_ADDR_OUT_A, 8'h0F);
		chk(pu, 16'h000F);
		wr(GP_ADDR_PUE_A, 8'hF0);
		chk(pu, 16'h00FF);
		wr(GP_ADDR_MICRO_CTRL, 8'h40);
		chk(pu, 16'h0000);
		wr(GP_ADDR_MICRO_CTRL, 8'h00);
		wr(GP_ADDR_PUE_A, 8'h00);
		ext_en <= 16'hFF00;
		wr(GP_ADDR_DIR_A, 8'hFF);
		chk({oe_n[7:0], pu[7:0]}, 16'h0000);
		wr(GP_ADDR_IN_A, 8'h01);
		rd(GP_ADDR_OUT_A, 8'h0E);
		rd(GP_ADDR_DIR_A, 8'hFF);
		rd(GP_ADDR_IN_A, 8'h0E);
		$display("Test port A done");
		ext_en <= 16'h00FF;
		wr(GP_ADDR_OUT_B, 8'hA5);
		wr(GP_ADDR_DIR_B, 8'hFF);
		chk({oe_n[15:8], pin_o[15:8]}, 16'h00A5);
		rd(GP_ADDR_IN_B, 8'hA5);
		wr(GP_ADDR_IN_B, 8'h0F);
		rd(GP_ADDR_OUT_B, 8'hAA);
		rd(GP_ADDR_IN_B, 8'hAA);
		wr(GP_ADDR_DIR_B, 8'h00);
		wr(GP_ADDR_OUT_B, 8'h00);
		wr(GP_ADDR_DIR_A, 8'h00);
		wr(GP_ADDR_OUT_A, 8'h01);
		chk(16'(pu[0]), 16'h0001);
		wr(GP_ADDR_OUT_A, 8'h00);
		wr(GP_ADDR_DIR_A, 8'h01);
		chk({14'h0000, oe_n[0], pin_o[0]}, 16'h0000);
		wr(GP_ADDR_DIR_A, 8'h00);
		$display("Test port B done");
		ext_en <= 16'hFFFF;
		ext_val <= 16'h00FF;
		sleep <= 1'b1;
		eie <= 16'h0001;
		rd(GP_ADDR_IN_A, 8'h01);
		sleep <= 1'b0;
		rd(GP_ADDR_IN_A, 8'hFF);
		$display("Test sleep done");
		wr(GP_ADDR_GEN_INT_MASK, 8'h10);
		pulse(8, 1);
		chk({15'h0000, flag}, 16'h0001);
		wr(GP_ADDR_FLAG, 8'h20);
		chk({15'h0000, flag}, 16'h0000);
		pulse(12, 0);
		wr(GP_ADDR_GEN_INT_MASK, 8'h20);
		pulse(12, 1);
		pulse(9, 0);
		wr(GP_ADDR_PC_MASK_HIGH, 8'hEF);
		pulse(12, 0);
		pulse(13, 1);
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		#1;
		chk({15'h0000, flag}, 16'h0000);
		$display("Test pin change done");
		stop_test();
	end

	// Tests take about 110 cycles; the watchdog allows some 36 times that
	initial begin
		#100000;
		fail_count++;
		$display("Watchdog expired");
		stop_test();
	end
endmodule
